// File: hw/fcs_defs.svh
// Register map, field positions and reset values of the flash status block
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH
// Register indices; the byte address is four times the index
`define FCS_IDX_CONFIG   6'h04
`define FCS_IDX_STATUS   6'h06
`define FCS_IDX_EVSTAT   6'h08
`define FCS_IDX_EVENA    6'h09
`define FCS_IDX_EVCLR    6'h0A
// Flash status fields
`define FCS_B_DONE       3'h7
`define FCS_B_ACC_ERR    3'h5
`define FCS_B_PVIOL      3'h4
`define FCS_B_BUSY       3'h3
`define FCS_B_RSVD       3'h2
`define FCS_B_MGST_HI    3'h1
`define FCS_B_MGST_LO    3'h0
// Config field: command-complete interrupt enable
`define FCS_B_DONE_IE    3'h7
// Event register bits
`define FCS_EV_DONE      2'h0
`define FCS_EV_ACC_ERR   2'h1
`define FCS_EV_PVIOL     2'h2
`define FCS_EV_W         3
// Reset values
`define FCS_RST_BYTE     8'h00
`define FCS_RST_EV       3'h0
`define FCS_RST_MGST     2'h0
`endif

// File: hw/fcs_pkg.sv
// Types shared by the flash status block
package fcs_pkg;
    typedef enum logic [1:0] {
        FCS_INIT = 2'b00,
        FCS_IDLE = 2'b01,
        FCS_EXEC = 2'b10
    } fcs_state_e;

    // Completion result handed in by the memory controller
    typedef struct packed {
        logic       valid;
        logic [1:0] err;
    } fcs_result_s;
endpackage : fcs_pkg

// File: hw/fcs_status.sv
// Flash command status register with launch control, APB slave and interrupt
// Behaviour
// - Bit 7 command_done_flag, 0 while command runs
// - Writing one to bit 7 launches command
// - Done flag stays low until finish or violation
// - Access error bit 5 on sequence violation
// - Access error set blocks command launch
// - Access error cleared only by writing one
// - Protection violation bit 4 on protected access
// - Protection violation cleared only by writing one
// - Protection violation blocks launch and new sequence
// - Busy bit 3 high while command executes
// - Bit 2 always reads zero
// - Two-bit error status set on detected errors
// - Busy and error bits ignore writes
// - Reset sequence result captured into status
// - Done interrupt when enabled and flag set
`timescale 1ns/1ps
`include "fcs_defs.svh"

module fcs_status
    import fcs_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire fcs_result_s CMD_RESULT,
    input  wire fcs_result_s RSEQ_RESULT,
    input  wire logic        SEQ_VIOL,
    input  wire logic        PROT_VIOL,
    output logic             CMD_LAUNCH,
    output logic             SEQ_ALLOW,
    output logic             IRQ
);

    fcs_state_e              state_q;
    fcs_state_e              state_d;
    logic                    acc_err_q;
    logic                    pviol_q;
    logic [1:0]              mgst_q;
    logic                    done_ie_q;
    logic [`FCS_EV_W-1:0]    ev_stat_q;
    logic [`FCS_EV_W-1:0]    ev_ena_q;
    logic [`FCS_EV_W-1:0]    ev_set;
    logic [`FCS_EV_W-1:0]    ev_clr;
    logic [31:0]             prdata_q;
    logic [31:0]             rdata;
    logic [7:0]              status_img;
    logic                    done_flag;
    logic                    busy_flag;
    logic                    wr_en;
    logic                    hit_cfg;
    logic                    hit_stat;
    logic                    hit_evs;
    logic                    hit_evn;
    logic                    hit_evc;
    logic                    launch;
    logic                    finish;
    logic                    abort;

    // Register decode on word addresses
    assign hit_cfg  = PADDR == {`FCS_IDX_CONFIG, 2'b00};
    assign hit_stat = PADDR == {`FCS_IDX_STATUS, 2'b00};
    assign hit_evs  = PADDR == {`FCS_IDX_EVSTAT, 2'b00};
    assign hit_evn  = PADDR == {`FCS_IDX_EVENA, 2'b00};
    assign hit_evc  = PADDR == {`FCS_IDX_EVCLR, 2'b00};

    // Ready follows the clock enable so no write is lost while frozen
    assign PREADY  = CE;
    assign PSLVERR = PSEL && PENABLE && !(hit_cfg || hit_stat || hit_evs
                                          || hit_evn || hit_evc);
    assign wr_en   = CE && PSEL && PENABLE && PWRITE;

    // Flag views of the command state
    assign done_flag = state_q == FCS_IDLE;
    assign busy_flag = state_q == FCS_EXEC;

    // Launch only from idle with both error flags clear
    assign launch = wr_en && hit_stat && PWDATA[`FCS_B_DONE] && done_flag
                    && !acc_err_q && !pviol_q;
    assign finish = CE && busy_flag && CMD_RESULT.valid;
    assign abort  = CE && busy_flag && SEQ_VIOL;

    assign CMD_LAUNCH = launch;
    // A new write sequence may not start while a protection fault stands
    assign SEQ_ALLOW  = !pviol_q;

    // Command state machine
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            FCS_INIT:
            begin
                if (RSEQ_RESULT.valid)
                    state_d = FCS_IDLE;
            end
            FCS_IDLE:
            begin
                if (launch)
                    state_d = FCS_EXEC;
            end
            FCS_EXEC:
            begin
                if (finish || abort)
                    state_d = FCS_IDLE;
            end
            default: state_d = FCS_INIT;
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            state_q <= FCS_INIT;
        else if (CE)
            state_q <= state_d;
    end

    // Access error: set wins over the clear in the same cycle
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            acc_err_q <= 1'b0;
        else if (CE)
        begin
            if (SEQ_VIOL)
                acc_err_q <= 1'b1;
            else if (wr_en && hit_stat && PWDATA[`FCS_B_ACC_ERR])
                acc_err_q <= 1'b0;
        end
    end

    // Protection violation, same write-one-to-clear form
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            pviol_q <= 1'b0;
        else if (CE)
        begin
            if (PROT_VIOL)
                pviol_q <= 1'b1;
            else if (wr_en && hit_stat && PWDATA[`FCS_B_PVIOL])
                pviol_q <= 1'b0;
        end
    end

    // Completion status; software writes reach it only by a launch, which clears it
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            mgst_q <= `FCS_RST_MGST;
        else if (CE)
        begin
            if (state_q == FCS_INIT && RSEQ_RESULT.valid)
                mgst_q <= RSEQ_RESULT.err;
            else if (launch)
                mgst_q <= `FCS_RST_MGST;
            else if (finish)
                mgst_q <= CMD_RESULT.err;
        end
    end

    // Config register: only the done interrupt enable is kept
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            done_ie_q <= 1'b0;
        else if (wr_en && hit_cfg)
            done_ie_q <= PWDATA[`FCS_B_DONE_IE];
    end

    // Sticky events; a set in the clearing cycle survives
    assign ev_set[`FCS_EV_DONE]    = finish || abort;
    assign ev_set[`FCS_EV_ACC_ERR] = CE && SEQ_VIOL;
    assign ev_set[`FCS_EV_PVIOL]   = CE && PROT_VIOL;
    assign ev_clr = (wr_en && hit_evc) ? PWDATA[`FCS_EV_W-1:0] : `FCS_RST_EV;

    generate
        for (genvar i = 0; i < `FCS_EV_W; i++)
        begin : g_ev
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                    ev_stat_q[i] <= 1'b0;
                else if (ev_set[i])
                    ev_stat_q[i] <= 1'b1;
                else if (ev_clr[i])
                    ev_stat_q[i] <= 1'b0;
            end
        end
    endgenerate

    // Event enable register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ev_ena_q <= `FCS_RST_EV;
        else if (wr_en && hit_evn)
            ev_ena_q <= PWDATA[`FCS_EV_W-1:0];
    end

    // Level interrupt from the done flag and enabled events
    assign IRQ = (done_ie_q && done_flag)
                 || |(ev_stat_q & ev_ena_q);

    // Status image; busy and error bits are read-only
    always_comb
    begin
        status_img                 = `FCS_RST_BYTE;
        status_img[`FCS_B_DONE]    = done_flag;
        status_img[`FCS_B_ACC_ERR] = acc_err_q;
        status_img[`FCS_B_PVIOL]   = pviol_q;
        status_img[`FCS_B_BUSY]    = busy_flag;
        status_img[`FCS_B_RSVD]    = 1'b0;
        status_img[`FCS_B_MGST_HI] = mgst_q[1];
        status_img[`FCS_B_MGST_LO] = mgst_q[0];
    end

    // Read mux; the clear register reads as zero
    always_comb
    begin
        rdata = 32'h0000_0000;
        if (hit_stat)
            rdata[7:0] = status_img;
        else if (hit_cfg)
            rdata[`FCS_B_DONE_IE] = done_ie_q;
        else if (hit_evs)
            rdata[`FCS_EV_W-1:0] = ev_stat_q;
        else if (hit_evn)
            rdata[`FCS_EV_W-1:0] = ev_ena_q;
    end

    // Read data captured each selected cycle with the clock enable high; valid by the access edge
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            prdata_q <= 32'h0000_0000;
        else if (CE && PSEL)
            prdata_q <= rdata;
    end

    assign PRDATA = prdata_q;

    AST_DONE_BUSY_EXCL: assert property (@(posedge CLK) disable iff (RST)
        !(done_flag && busy_flag))
        else $error("done and busy both set");

    AST_LAUNCH_CLEARS: assert property (@(posedge CLK) disable iff (RST)
        launch |=> (!status_img[`FCS_B_DONE] && status_img[`FCS_B_BUSY]))
        else $error("launch did not clear done");

    AST_DONE_LOW_UNTIL: assert property (@(posedge CLK) disable iff (RST)
        (busy_flag && !(CE && (CMD_RESULT.valid || SEQ_VIOL))) |=> !done_flag)
        else $error("done rose without finish");

    AST_ACC_ERR_SET: assert property (@(posedge CLK) disable iff (RST)
        (CE && SEQ_VIOL) |=> status_img[`FCS_B_ACC_ERR])
        else $error("access error not set");

    AST_ACC_ERR_BLOCKS: assert property (@(posedge CLK) disable iff (RST)
        acc_err_q |-> !CMD_LAUNCH)
        else $error("launch with access error");

    AST_ACC_ERR_W0: assert property (@(posedge CLK) disable iff (RST)
        (acc_err_q && !(wr_en && hit_stat && PWDATA[`FCS_B_ACC_ERR])) |=> acc_err_q)
        else $error("access error lost");

    AST_PVIOL_SET: assert property (@(posedge CLK) disable iff (RST)
        (CE && PROT_VIOL) |=> status_img[`FCS_B_PVIOL])
        else $error("protection flag not set");

    AST_PVIOL_W1C: assert property (@(posedge CLK) disable iff (RST)
        (CE && pviol_q && !PROT_VIOL && wr_en && hit_stat && PWDATA[`FCS_B_PVIOL])
        |=> !pviol_q)
        else $error("protection flag not cleared");

    AST_PVIOL_BLOCKS: assert property (@(posedge CLK) disable iff (RST)
        pviol_q |-> (!CMD_LAUNCH && !SEQ_ALLOW))
        else $error("launch or sequence with violation");

    AST_RSVD_ZERO: assert property (@(posedge CLK) disable iff (RST)
        (PSEL && PENABLE && hit_stat) |-> (PRDATA[`FCS_B_RSVD] == 1'b0))
        else $error("reserved bit read one");

    AST_MGST_RESULT: assert property (@(posedge CLK) disable iff (RST)
        finish |=> (mgst_q == $past(CMD_RESULT.err)))
        else $error("error status not captured");

    AST_MGST_RO: assert property (@(posedge CLK) disable iff (RST)
        (wr_en && hit_stat && !launch && !finish && state_q != FCS_INIT)
        |=> $stable(mgst_q))
        else $error("error status written");

    AST_RSEQ_CAPTURE: assert property (@(posedge CLK) disable iff (RST)
        (CE && state_q == FCS_INIT && RSEQ_RESULT.valid)
        |=> (mgst_q == $past(RSEQ_RESULT.err) && done_flag))
        else $error("reset result not captured");

    AST_IRQ_DONE: assert property (@(posedge CLK) disable iff (RST)
        (done_ie_q && done_flag) |-> IRQ)
        else $error("done interrupt missing");

    AST_MGST_CLEAR: assert property (@(posedge CLK) disable iff (RST)
        launch |=> (mgst_q == `FCS_RST_MGST) [*1] ##1 1'b1)
        else $error("error status not cleared on launch");

    // Ends of a command, flag holding and the clock enable freeze
    AST_ABORT_ENDS: assert property (@(posedge CLK) disable iff (RST)
        (CE && busy_flag && SEQ_VIOL) |=> (done_flag && !busy_flag))
        else $error("violation did not end command");

    AST_FINISH_ENDS: assert property (@(posedge CLK) disable iff (RST)
        (CE && busy_flag && CMD_RESULT.valid) |=> (status_img[`FCS_B_DONE] && !busy_flag))
        else $error("done not set at completion");

    AST_ACC_ERR_W1C: assert property (@(posedge CLK) disable iff (RST)
        (CE && acc_err_q && !SEQ_VIOL && wr_en && hit_stat && PWDATA[`FCS_B_ACC_ERR])
        |=> !acc_err_q)
        else $error("access error not cleared");

    AST_PVIOL_W0: assert property (@(posedge CLK) disable iff (RST)
        (pviol_q && !(wr_en && hit_stat && PWDATA[`FCS_B_PVIOL])) |=> pviol_q)
        else $error("protection flag lost");

    // Frozen state keeps a stalled bus from seeing half an update
    AST_CE_FREEZE: assert property (@(posedge CLK) disable iff (RST)
        !CE |=> ($stable(state_q) && $stable(acc_err_q) && $stable(pviol_q)
                 && $stable(mgst_q) && $stable(ev_stat_q)))
        else $error("state moved while clock enable low");

    AST_SEQ_ALLOW_FREE: assert property (@(posedge CLK) disable iff (RST)
        !pviol_q |-> SEQ_ALLOW)
        else $error("write sequence refused without violation");

    AST_LAUNCH_IDLE_ONLY: assert property (@(posedge CLK) disable iff (RST)
        CMD_LAUNCH |-> (done_flag && !busy_flag))
        else $error("launch while command running");

endmodule : fcs_status

// File: bench/fcs_status_test.sv
// Self-checking bench of the flash status register block
`timescale 1ns/1ps
`include "fcs_defs.svh"

module fcs_status_test
    import fcs_pkg::*;
;
    logic        clk, rst, ce, psel, penable, pwrite, seq_viol, prot_viol;
    logic        pready, pslverr, launch, seq_allow, irq, slv, lau;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  e;
    fcs_result_s cmd_res, rseq_res;
    int          n_errors, n_tests;

    fcs_status uut (
        .CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CMD_RESULT(cmd_res), .RSEQ_RESULT(rseq_res),
        .SEQ_VIOL(seq_viol), .PROT_VIOL(prot_viol), .CMD_LAUNCH(launch),
        .SEQ_ALLOW(seq_allow), .IRQ(irq)
    );

    // 200 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // Expected status word from flags {done, access, protect, busy} and error status
    function automatic logic [31:0] flash_status(input logic [3:0] f, input logic [1:0] er);
        return {24'h0, f[3], 1'h0, f[2:0], 1'h0, er};
    endfunction : flash_status

    // Case equality, so an unknown never matches
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // One APB transfer; data and launch strobe taken at the edge that sees pready
    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        if (n >= 50)
        begin
            n_errors++;
            $display("CHECK FAILED pready expected 1 seen timeout");
            complete_run();
        end
        rd  = prdata;
        slv = pslverr;
        lau = launch;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rs(input logic [31:0] exp);
        apb(1'h0, `FCS_IDX_STATUS, 32'h0);
        chk("flash_status", exp, rd);
    endtask : rs

    // One-cycle controller event: 0 result, 1 reset sequence, 2 sequence, 3 protect
    task automatic ev(input int k, input logic [1:0] er);
        @(posedge clk);
        cmd_res   <= '{k == 0, er};
        rseq_res  <= '{k == 1, er};
        seq_viol  <= (k == 2);
        prot_viol <= (k == 3);
        @(posedge clk);
        cmd_res   <= '0;
        rseq_res  <= '0;
        seq_viol  <= 1'h0;
        prot_viol <= 1'h0;
    endtask : ev

    // Main sequence
    initial
    begin
        {rst, ce, psel, penable, pwrite, seq_viol, prot_viol} = 7'h60;
        {paddr, pwdata, cmd_res, rseq_res} = '0;
        n_errors = 0;
        n_tests  = 0;
        void'($urandom(32'h2C49));
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rs(flash_status(4'h0, 2'h0));
        apb(1'h1, `FCS_IDX_STATUS, 32'h80);
        chk("launch", 32'h0, lau);
        ev(1, 2'h3);
        rs(flash_status(4'h8, 2'h3));
        apb(1'h1, `FCS_IDX_STATUS, 32'h4F);
        rs(flash_status(4'h8, 2'h3));
        $display("test reset_sequence ended");
        // Random result codes; first pass also freezes the clock enable
        for (int i = 0; i < 8; i++)
        begin
            e = 2'($urandom);
            apb(1'h1, `FCS_IDX_STATUS, 32'h80);
            chk("launch", 32'h1, lau);
            rs(flash_status(4'h1, 2'h0));
            apb(1'h1, `FCS_IDX_STATUS, 32'h80);
            chk("launch", 32'h0, lau);
            if (i == 0)
            begin
                @(posedge clk);
                ce <= 1'h0;
                ev(0, e);
                @(posedge clk);
                ce <= 1'h1;
                rs(flash_status(4'h1, 2'h0));
            end
            ev(0, e);
            rs(flash_status(4'h8, e));
        end
        $display("test command_cycle ended");
        apb(1'h1, `FCS_IDX_STATUS, 32'h80);
        ev(2, 2'h0);
        rs(flash_status(4'hC, 2'h0));
        apb(1'h1, `FCS_IDX_STATUS, 32'h80);
        chk("launch", 32'h0, lau);
        apb(1'h1, `FCS_IDX_STATUS, 32'h0);
        rs(flash_status(4'hC, 2'h0));
        apb(1'h1, `FCS_IDX_STATUS, 32'hA0);
        chk("launch", 32'h0, lau);
        rs(flash_status(4'h8, 2'h0));
        $display("test access_error ended");
        ev(3, 2'h0);
        @(negedge clk);
        chk("seq_allow", 32'h0, seq_allow);
        rs(flash_status(4'hA, 2'h0));
        apb(1'h1, `FCS_IDX_STATUS, 32'h80);
        chk("launch", 32'h0, lau);
        apb(1'h1, `FCS_IDX_STATUS, 32'h0);
        rs(flash_status(4'hA, 2'h0));
        apb(1'h1, `FCS_IDX_STATUS, 32'h10);
        rs(flash_status(4'h8, 2'h0));
        @(negedge clk);
        chk("seq_allow", 32'h1, seq_allow);
        $display("test protect_violation ended");
        // Interrupt: done enable, then sticky event with enable and clear
        apb(1'h1, `FCS_IDX_EVCLR, 32'h7);
        apb(1'h1, `FCS_IDX_EVENA, 32'h0);
        apb(1'h1, `FCS_IDX_CONFIG, 32'h0);
        @(negedge clk);
        chk("irq", 32'h0, irq);
        apb(1'h1, `FCS_IDX_CONFIG, 32'h80);
        @(negedge clk);
        chk("irq", 32'h1, irq);
        apb(1'h0, `FCS_IDX_CONFIG, 32'h0);
        chk("config", 32'h80, rd);
        apb(1'h1, `FCS_IDX_STATUS, 32'h80);
        @(negedge clk);
        chk("irq", 32'h0, irq);
        ev(0, 2'h0);
        @(negedge clk);
        chk("irq", 32'h1, irq);
        apb(1'h1, `FCS_IDX_CONFIG, 32'h0);
        apb(1'h0, `FCS_IDX_EVSTAT, 32'h0);
        chk("event_status", 32'h1, rd);
        apb(1'h1, `FCS_IDX_EVENA, 32'h1);
        @(negedge clk);
        chk("irq", 32'h1, irq);
        apb(1'h1, `FCS_IDX_EVCLR, 32'h1);
        @(negedge clk);
        chk("irq", 32'h0, irq);
        apb(1'h0, `FCS_IDX_EVCLR, 32'h0);
        chk("event_clear", 32'h0, rd);
        apb(1'h0, 6'h3F, 32'h0);
        chk("pslverr", 32'h1, slv);
        chk("unmapped", 32'h0, rd);
        $display("test interrupt ended");
        complete_run();
    end
endmodule : fcs_status_test
